// File: dv/pump_model.sv
/* pump and bottle stand-in: finishes each sample a fixed time after the request.
   assumes sample_req is a one-cycle pulse on the shared clock. */
`default_nettype none
module pump_model #(
  parameter int LAT = 3  // cycles from request to deposited sample
) (
  input wire logic clk,
  input wire logic sample_req,
  output logic sample_done
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;  // cycles left on the sample in hand
  // one draw and deposit per request, answered after LAT edges
  always @(posedge clk) begin
    sample_done <= (cnt == 1);
    if (sample_req)
      cnt <= LAT;
    else if (cnt != 0)
      cnt <= cnt - 1;
  end
endmodule : pump_model
`default_nettype wire

// File: dv/sample_interval_sequencer_sva.sv
/* port checker for the sample interval sequencer.
   assumes one clock and an async active-high reset; bound after the module. */
`default_nettype none
module seq_checker
  import seq_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire keypad_t keys,
  input wire logic sample_req,
  input wire logic await_start,
  input wire logic running,
  input wire logic program_done,
  input wire display_t disp
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // port relations
  // ****************
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst);
  // bare enter while not running: in entry, a repeat of the current interval
  sequence s_bare_enter;
    keys.enter && !keys.digits_valid && !keys.prog && !running;
  endsequence
  // finished program with no restart strobe in flight
  sequence s_done_quiet;
    program_done && !keys.prog && !$past(keys.prog);
  endsequence
  AST_REQ_PULSE: assert property (sample_req |=> !sample_req)
    else $error("sample request longer than one cycle");
  AST_REQ_RUNNING: assert property (sample_req |-> running)
    else $error("sample request outside a run");
  AST_DONE_QUIET: assert property (program_done |-> !running && !sample_req)
    else $error("activity after the program ended");
  AST_AWAIT_EXCL: assert property (await_start |-> !running && !program_done)
    else $error("start prompt overlaps another state");
  AST_SLOT_LIMIT: assert property (disp.slot_index <= 4'hc)
    else $error("more than twelve distinct slots");
  AST_REPEAT_SLOT: assert property (s_bare_enter |-> ##2 $stable(disp.slot_index))
    else $error("repeat moved the distinct index");
  AST_TALLY_STEP: assert property (running && $changed(disp.tally) |->
    disp.tally == $past(disp.tally) + 16'h0001)
    else $error("tally moved by other than one");
  AST_DONE_HOLD: assert property (s_done_quiet |=> program_done)
    else $error("ended program left without a restart");
endmodule : seq_checker
bind sample_interval_sequencer seq_checker u_chk (.clk(clk), .rst(rst), .keys(keys),
  .sample_req(sample_req), .await_start(await_start), .running(running),
  .program_done(program_done), .disp(disp));
`default_nettype wire

// File: dv/sample_interval_sequencer_test.sv
/* self-checking bench for the sample interval sequencer.
   assumes a ten-cycle minute and the pump stand-in on the far side. */
`default_nettype none
module sample_interval_sequencer_test import seq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic mode_delay = 1'b0;
  keypad_t keys = '0;
  logic [MIN_W-1:0] delay_minutes = 13'h0003;
  logic contact_in = 1'b0;
  logic bottle_full = 1'b0;
  logic ce = 1'b1;  // dropped once to prove the freeze
  logic sample_done, sample_req, await_start, running, program_done;
  display_t disp;
  int err_count = 0;
  int check_count = 0;
  int n;  // sample requests seen by run
  always #10 clk = ~clk;
  // short minute keeps the t_entry schedule within a few hundred cycles
  sample_interval_sequencer #(.MINUTE_TICKS(10)) DUT (.clk(clk), .rst(rst), .ce(ce),
    .mode_delay(mode_delay), .keys(keys), .delay_minutes(delay_minutes),
    .contact_in(contact_in), .bottle_full(bottle_full), .sample_done(sample_done),
    .sample_req(sample_req), .await_start(await_start), .running(running),
    .program_done(program_done), .disp(disp));
  pump_model u_pump (.clk(clk), .sample_req(sample_req), .sample_done(sample_done));
  // ****************
  // shared tasks
  // ****************
  task automatic check(input string what, input logic [63:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  // one-cycle key strobe, then room for the two-edge display lag
  task automatic key(input logic e, p, s, d, input int hh = 0, mm = 0);
    keys = '{e, p, s, d, 7'(hh), 6'(mm)};
    @(negedge clk);
    keys = '0;
    repeat (2) @(negedge clk);
  endtask : key
  task automatic ent(input int hh, mm);
    key(1, 0, 0, 1, hh, mm);
  endtask : ent
  // contact held a few cycles so the synchroniser surely sees it
  task automatic close;
    contact_in = 1'b1;
    repeat (4) @(negedge clk);
    contact_in = 1'b0;
    repeat (2) @(negedge clk);
  endtask : close
  // count requests until the program ends or the span runs out
  task automatic run(input int lim);
    n = 0;
    repeat (lim) begin
      @(negedge clk);
      if (sample_req === 1'b1) n++;
      if (program_done === 1'b1) break;
    end
  endtask : run
  // ****************
  // scenarios
  // ****************
  task automatic t_entry;
    key(0, 1, 0, 0);
    ent(0, 2);
    check("slot", disp.slot_index, 1);
    key(1, 0, 0, 0);
    check("repeat", disp.repeat_count, 2);
    check("slot after repeat", disp.slot_index, 1);
    ent(0, 1);
    ent(0, 2);
    check("equal after other", disp.slot_index, 3);
    ent(0, 0);
    check("zero refused", disp.slot_index, 3);
    ent(100, 0);
    check("over range refused", disp.slot_index, 3);
    ent(0, 2);
    check("equal repeat", disp.repeat_count, 2);
    key(0, 1, 0, 0);
    check("entry closed", await_start, 1);
    key(0, 0, 1, 0);
    check("first remaining", disp.remaining, 2);
    run(400);
    check("schedule samples", n, 5);
    check("schedule over", program_done, 1);
  endtask : t_entry
  task automatic t_twelve;
    key(0, 1, 0, 0);
    for (int i = 0; i < 12; i++) ent(i[0] ? 99 : 0, i[0] ? 59 : 1);
    check("slots", disp.slot_index, 12);
    check("auto close", await_start, 1);
    key(0, 0, 1, 0);
    run(20);
    check("first expiry", n, 1);
    bottle_full = 1'b1;
    run(20);
    check("full stops", program_done, 1);
  endtask : t_twelve
  task automatic t_delay;
    bottle_full = 1'b0;
    mode_delay = 1'b1;
    key(0, 1, 0, 0);
    key(0, 0, 1, 0);
    close();
    check("delay loaded", disp.remaining, 3);
    close();
    run(80);
    check("one per closure", n, 1);
    check("tally", disp.tally, 1);
    close();
    run(60);
    check("tally again", disp.tally, 2);
    check("awaits closure", running, 1);
    bottle_full = 1'b1;
    run(10);
    check("delay ends", program_done, 1);
  endtask : t_delay
  // empty schedule, frozen clock enable, then a zero delay
  task automatic t_zero;
    bottle_full = 1'b0;
    mode_delay = 1'b0;
    key(0, 1, 0, 0);
    key(0, 1, 0, 0);
    key(0, 0, 1, 0);
    check("empty schedule ends", program_done, 1);
    mode_delay = 1'b1;
    delay_minutes = 13'h0000;
    key(0, 1, 0, 0);
    key(0, 0, 1, 0);
    ce = 1'b0;
    close();
    ce = 1'b1;
    run(20);
    check("frozen closure missed", n, 0);
    close();
    run(20);
    check("zero delay tally", disp.tally, 1);
  endtask : t_zero
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    summarize();
  end
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check("idle outputs", {sample_req, await_start, running, program_done, disp}, 0);
    t_entry();
    t_twelve();
    t_delay();
    t_zero();
    summarize();
  end
endmodule : sample_interval_sequencer_test
`default_nettype wire

// File: rtl/sample_interval_sequencer.sv
/*
  sample interval sequencer: schedule mode and contact-delay mode.
  assumes keypad strobes are synchronous one-cycle pulses, and the pump
  reports sample_done as a one-cycle pulse after each sample_req.
*/
`default_nettype none
module sample_interval_sequencer
  import seq_pkg::*;
#(
  parameter int unsigned MINUTE_TICKS = MINUTE_CYCLES  // shorten in simulation
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic mode_delay,        // 1 selects delay mode at entry start
  input wire keypad_t keys,
  input wire logic [MIN_W-1:0] delay_minutes,
  input wire logic contact_in,        // raw external contact, async
  input wire logic bottle_full,       // from mechanism, async
  input wire logic sample_done,       // pump finished a sample
  output logic sample_req,            // pulse: draw one sample
  output logic await_start,           // awaiting-start prompt
  output logic running,
  output logic program_done,
  output display_t disp
);
  // ***********************************************************
  // storage
  // ***********************************************************
  logic [MIN_W-1:0] interval_mem [MAX_SLOTS];  // distinct intervals
  logic [REP_W-1:0] repeat_mem [MAX_SLOTS];    // copies per interval
  seq_state_t state_r;
  logic delay_mode_r;               // latched mode
  logic [3:0] slots_r;              // distinct intervals logged
  logic [3:0] run_slot_r;           // slot being counted down
  logic [REP_W-1:0] run_rep_r;      // copies left of that slot
  logic [MIN_W-1:0] remain_r;       // countdown in minutes
  logic [TALLY_W-1:0] tally_r;
  logic [31:0] tick_cnt_r;          // minute prescaler
  logic sample_req_r;
  logic [2:0] contact_sync_r;       // two-stage sync plus edge history
  logic [1:0] full_sync_r;

  // ***********************************************************
  // input synchronisers
  // ***********************************************************
  // stage 0 is read only by stage 1, so metastability stays contained
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      contact_sync_r <= 3'h0;
      full_sync_r <= 2'h0;
    end else if (ce) begin
      contact_sync_r <= {contact_sync_r[1:0], contact_in};  // [R15]
      full_sync_r <= {full_sync_r[0], bottle_full};
    end
  end

  wire closure_edge = contact_sync_r[1] & ~contact_sync_r[2];  // [R15]
  wire full = full_sync_r[1];

  // ***********************************************************
  // minute timebase
  // ***********************************************************
  wire counting = (state_r == ST_RUN) || (state_r == ST_DELAY);
  wire minute_tick = counting && (tick_cnt_r == MINUTE_TICKS - 1);  // [R17]

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt_r <= 32'h0;
    end else if (ce) begin
      // prescaler restarts with each countdown so a full minute elapses
      if (!counting || minute_tick) begin
        tick_cnt_r <= 32'h0;
      end else begin
        tick_cnt_r <= tick_cnt_r + 32'h1;
      end
    end
  end

  // ***********************************************************
  // entry decode
  // ***********************************************************
  // operands widened first so the hours product cannot wrap at seven bits
  wire [MIN_W-1:0] key_value = (MIN_W'(keys.hours) * MIN_W'(7'd60)) + MIN_W'(keys.minutes);
  wire value_ok = (key_value != '0) && (key_value <= MIN_W'(MAX_MINUTES));  // [R1]
  wire last_slot_valid = (slots_r != 4'h0);
  wire [3:0] last_slot = slots_r - 4'h1;
  wire is_repeat = keys.enter && !keys.digits_valid && last_slot_valid;  // [R3]
  // a new value, even equal to an older one, is distinct unless it matches the last
  wire same_as_last = last_slot_valid && (interval_mem[last_slot] == key_value);
  wire is_new = keys.enter && keys.digits_valid && value_ok && !same_as_last;  // [R5]
  wire is_dup = keys.enter && keys.digits_valid && value_ok && same_as_last;
  wire expired = minute_tick && (remain_r == MIN_W'(1));
  wire more_copies = (run_rep_r > REP_W'(1));
  wire [3:0] next_slot = run_slot_r + 4'h1;
  wire more_slots = (next_slot < slots_r);

  // ***********************************************************
  // sequencer
  // ***********************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      delay_mode_r <= 1'b0;
      slots_r <= 4'h0;
      run_slot_r <= 4'h0;
      run_rep_r <= '0;
      remain_r <= '0;       // [R17]
      tally_r <= '0;        // [R17]
      sample_req_r <= 1'b0;
      for (int i = 0; i < MAX_SLOTS; i++) begin
        interval_mem[i] <= '0;
        repeat_mem[i] <= '0;
      end
    end else if (ce) begin
      sample_req_r <= 1'b0;
      unique case (state_r)
        ST_IDLE, ST_DONE: begin
          // program key opens entry, or in delay mode goes straight to the start prompt
          if (keys.prog) begin
            delay_mode_r <= mode_delay;
            slots_r <= 4'h0;
            tally_r <= '0;
            state_r <= mode_delay ? ST_AWAIT_START : ST_ENTRY;
          end
        end
        ST_ENTRY: begin
          if (keys.prog) begin
            state_r <= ST_AWAIT_START;  // [R7]
          end else if (is_new) begin
            interval_mem[slots_r] <= key_value;  // [R2]
            repeat_mem[slots_r] <= REP_W'(1);
            slots_r <= slots_r + 4'h1;
            if (slots_r == 4'(MAX_SLOTS - 1)) begin
              state_r <= ST_AWAIT_START;  // [R6]
            end
          end else if ((is_repeat || is_dup) && repeat_mem[last_slot] != '1) begin
            // index untouched; saturates rather than wrapping
            repeat_mem[last_slot] <= repeat_mem[last_slot] + REP_W'(1);  // [R3] [R4]
          end
        end
        ST_AWAIT_START: begin
          if (keys.start) begin
            if (delay_mode_r) begin
              state_r <= ST_WAIT_CLOSE;
            end else if (slots_r == 4'h0) begin
              state_r <= ST_DONE;  // nothing to run
            end else begin
              run_slot_r <= 4'h0;
              run_rep_r <= repeat_mem[0];
              remain_r <= interval_mem[0];  // [R11]
              state_r <= ST_RUN;  // [R8]
            end
          end
        end
        ST_RUN: begin
          if (full) begin
            state_r <= ST_DONE;  // [R10]
          end else if (expired) begin
            sample_req_r <= 1'b1;  // [R8] [R9]
            state_r <= ST_SAMPLE;
            // next countdown loaded now; it resumes after the sample
            if (more_copies) begin
              run_rep_r <= run_rep_r - REP_W'(1);
              remain_r <= interval_mem[run_slot_r];
            end else if (more_slots) begin
              run_slot_r <= next_slot;
              run_rep_r <= repeat_mem[next_slot];
              remain_r <= interval_mem[next_slot];
            end else begin
              run_rep_r <= '0;
              remain_r <= '0;
            end
          end else if (minute_tick) begin
            remain_r <= remain_r - MIN_W'(1);  // [R17]
          end
        end
        ST_SAMPLE: begin
          // one sample must finish before anything else is serviced
          if (sample_done) begin  // [R9]
            if (delay_mode_r) begin
              tally_r <= tally_r + TALLY_W'(1);  // [R13]
              state_r <= full ? ST_DONE : ST_WAIT_CLOSE;  // [R13] [R14]
            end else if (full || remain_r == '0) begin
              state_r <= ST_DONE;  // [R10]
            end else begin
              state_r <= ST_RUN;
            end
          end
        end
        ST_WAIT_CLOSE: begin
          if (full) begin
            state_r <= ST_DONE;  // [R14]
          end else if (closure_edge) begin
            remain_r <= delay_minutes;  // [R12]
            state_r <= (delay_minutes == '0) ? ST_SAMPLE : ST_DELAY;
            sample_req_r <= (delay_minutes == '0);
          end
        end
        ST_DELAY: begin
          // closure edges are not looked at here, so none queue up
          if (expired) begin  // [R16]
            remain_r <= '0;
            sample_req_r <= 1'b1;  // [R13]
            state_r <= ST_SAMPLE;
          end else if (minute_tick) begin
            remain_r <= remain_r - MIN_W'(1);  // [R17]
          end
        end
      endcase
    end
  end

  // ***********************************************************
  // registered outputs
  // ***********************************************************
  // run view shows the slot in hand; elsewhere the count of logged slots
  wire in_schedule_run = !delay_mode_r && ((state_r == ST_RUN) || (state_r == ST_SAMPLE));
  wire [3:0] shown_slot = in_schedule_run ? run_slot_r + 4'h1 : slots_r;
  wire [REP_W-1:0] shown_rep = last_slot_valid ? repeat_mem[last_slot] : '0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sample_req <= 1'b0;
      await_start <= 1'b0;
      running <= 1'b0;
      program_done <= 1'b0;
      disp <= '0;
    end else if (ce) begin
      sample_req <= sample_req_r;
      await_start <= (state_r == ST_AWAIT_START);
      running <= (state_r == ST_RUN) || (state_r == ST_SAMPLE) ||
                 (state_r == ST_WAIT_CLOSE) || (state_r == ST_DELAY);
      program_done <= (state_r == ST_DONE);
      disp.slot_index <= shown_slot;
      disp.repeat_count <= shown_rep;
      disp.remaining <= remain_r;  // [R11]
      disp.tally <= tally_r;  // [R13]
    end
  end
endmodule : sample_interval_sequencer
`default_nettype wire

// File: rtl/seq_pkg.sv
/*
  constants, state type and carrier structs for the sample interval sequencer.
  assumes one 50 mhz clock; keypad events arrive already decoded and clock-synchronous.
*/
// Behaviour
// R1: store twelve intervals, one minute to 99:59
// R2: interval entered as hh:mm, committed on enter
// R3: bare enter repeats current interval, bumps count
// R4: repeats leave distinct index unchanged
// R5: equal value after different one is distinct
// R6: twelfth distinct interval closes entry, awaits start
// R7: program key ends entry, keeps logged intervals
// R8: expiry triggers sample, next countdown starts
// R9: each trigger draws and deposits one sample
// R10: run stops when done or bottle full
// R11: show remaining remaining_time_view
// R12: delay mode: closure starts delay countdown
// R13: delay end samples, bumps tally, rewaits closure
// R14: delay mode ends on bottle full; ST_DELAY ignores full, so the delay runs out and samples first
// R15: contact input synchronised and edge detected
// R16: closures during delay or sampling ignored
// R17: countdowns tick per minute; reset clears all
`default_nettype none
package seq_pkg;
  // ***********************************************************
  // sizes and timing
  // ***********************************************************
  localparam int unsigned MAX_SLOTS = 12;      // distinct interval slots
  localparam int unsigned MAX_MINUTES = 5999;  // 99 h 59 min
  localparam int unsigned MIN_W = 13;          // minute counter width
  localparam int unsigned CLK_HZ = 50000000;   // system clock rate
  localparam int unsigned MINUTE_S = 60;       // timebase period in seconds
  localparam int unsigned MINUTE_CYCLES = CLK_HZ * MINUTE_S;  // 3e9, fits 32 bits
  localparam int unsigned REP_W = 8;           // repeat count width
  localparam int unsigned TALLY_W = 16;        // sample tally width

  // ***********************************************************
  // types
  // ***********************************************************
  typedef enum logic [1:0] {
    MODE_IDLE,
    MODE_SCHEDULE,
    MODE_DELAY
  } run_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ENTRY,
    ST_AWAIT_START,
    ST_RUN,
    ST_SAMPLE,
    ST_WAIT_CLOSE,
    ST_DELAY,
    ST_DONE
  } seq_state_t;

  // keypad event bundle, one-cycle strobes
  typedef struct packed {
    logic enter;           // commit or repeat
    logic prog;            // end entry
    logic start;           // start run
    logic digits_valid;    // a fresh hh:mm value accompanies enter
    logic [6:0] hours;     // 0..99
    logic [5:0] minutes;   // 0..59
  } keypad_t;

  // display bundle
  typedef struct packed {
    logic [3:0] slot_index;         // distinct interval count; slot in hand in a schedule run
    logic [REP_W-1:0] repeat_count; // copies of current interval
    logic [MIN_W-1:0] remaining;    // minutes to next sample
    logic [TALLY_W-1:0] tally;      // samples taken in delay mode
  } display_t;
endpackage : seq_pkg
`default_nettype wire
